//--- rtl/nac_pkg.sv
/*
  constants for the data nonvolatile access controller: special function
  register offsets, field positions, reset values and cycle counts.
  assumes the core's special function register port of 8-bit data.
*/
// Contract
// [R1] write permit bit 3, reset 0, gates every write cycle
// [R2] setting write strobe bit 2 starts a write; hardware clears it at end
// [R3] write strobe ignored unless write permit was already set
// [R4] read permit bit 1, reset 0, gates every read cycle
// [R5] setting read strobe bit 0 starts a read; hardware clears it at end
// [R6] read strobe ignored unless read permit was already set
// [R7] software never sets all four bits, nor both strobes, at once
// [R8] fetched byte sits in the byte register until next read or write
// [R9] software sets read permit, loads index, sets read strobe, then polls
// [R10] software loads index and byte, then permit and strobe back to back
// [R11] software clears global interrupt enable around write start
// [R12] write cycle timed by a timer asynchronous to the system clock
// [R13] power-on clears the write permit bit
// [R14] power-on clears the bank select register
// [R15] write end sets nvm flag and multi-function flag
// [R16] vector only with global, nvm, multi-function enables and stack free
// [R17] service clears only the multi-function flag; software clears nvm flag
// [R18] software sets nvm and multi-function enables for the interrupt
// [R19] control bits 7 to 4 read as zero
// [R20] software may read back written data and keep write permit clear
// [R21] control register sits at 40H of bank 1, reached only indirectly
// [R22] index register is 7 bits wide, selecting 128 bytes
// [R23] read cycle ends within a fixed small number of system clocks
package nac_pkg;
  localparam int unsigned NAC_ADDR_W    = 7;
  localparam int unsigned NAC_RD_CYCLES = 2;
  localparam int unsigned NAC_WR_TICKS  = 16;

  localparam logic [7:0] NAC_OFS_IND1  = 8'h02;
  localparam logic [7:0] NAC_OFS_PTR1  = 8'h03;
  localparam logic [7:0] NAC_OFS_BANK  = 8'h04;
  localparam logic [7:0] NAC_OFS_IRQ   = 8'h0E;
  localparam logic [7:0] NAC_OFS_INDEX = 8'h1E;
  localparam logic [7:0] NAC_OFS_BYTE  = 8'h1F;
  localparam logic [7:0] NAC_CTRL_ADDR = 8'h40;
  localparam logic [7:0] NAC_CTRL_BANK = 8'h01;

  localparam int unsigned NAC_B_RD_STB  = 0;
  localparam int unsigned NAC_B_RD_PERM = 1;
  localparam int unsigned NAC_B_WR_STB  = 2;
  localparam int unsigned NAC_B_WR_PERM = 3;

  localparam int unsigned NAC_B_GIE  = 0;
  localparam int unsigned NAC_B_NIE  = 1;
  localparam int unsigned NAC_B_MIE  = 2;
  localparam int unsigned NAC_B_NIF  = 3;
  localparam int unsigned NAC_B_MIF  = 4;

  localparam logic [7:0] NAC_RST_CTRL = 8'h00;
  localparam logic [7:0] NAC_RST_BANK = 8'h00;
  localparam logic [7:0] NAC_RST_IRQ  = 8'h00;
endpackage

//--- rtl/nac_store.sv
/*
  byte array with fixed-latency read and timer-paced write.
  assumes wr_timer_i is a free running tick from an unrelated oscillator.
*/
`timescale 1ns/1ps
module nac_store
  import nac_pkg::*;
#(
  parameter int unsigned AW       = NAC_ADDR_W,
  parameter int unsigned RD_CYC   = NAC_RD_CYCLES,
  parameter int unsigned WR_TICKS = NAC_WR_TICKS
)(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          wr_timer_i,
  input  wire logic          rd_start_i,
  input  wire logic          wr_start_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  output logic      [7:0]    rdata_o,
  output logic               rd_done_o,
  output logic               wr_done_o
);
  initial begin
    if (AW < 1 || AW > 8 || RD_CYC < 1 || RD_CYC > 255 ||
        WR_TICKS < 1 || WR_TICKS > 255) begin
      $error("nac_store: parameter out of range");
    end
  end

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} nac_st_t;

  logic [7:0]    mem [2**AW];
  nac_st_t       st_r;
  logic [7:0]    cnt_r;
  logic [AW-1:0] addr_r;
  logic [7:0]    data_r;
  logic          tk_s1_r;
  logic          tk_s2_r;
  logic          tk_s3_r;
  logic          tk_lvl_r;
  logic          tick;

  ////////////////////////////////////////////////////////////////////////
  // timer tick crossing: three stages, level taken when stages 2 and 3 agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tk_s1_r  <= 1'b0;
      tk_s2_r  <= 1'b0;
      tk_s3_r  <= 1'b0;
      tk_lvl_r <= 1'b0;
    end else begin
      tk_s1_r <= wr_timer_i;
      tk_s2_r <= tk_s1_r;
      tk_s3_r <= tk_s2_r;
      if (tk_s2_r == tk_s3_r) begin
        tk_lvl_r <= tk_s3_r;
      end
    end
  end
  assign tick = (tk_s2_r == tk_s3_r) && tk_s3_r && !tk_lvl_r;

  ////////////////////////////////////////////////////////////////////////
  // cycle sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r      <= ST_IDLE;
      cnt_r     <= 8'h00;
      addr_r    <= '0;
      data_r    <= 8'h00;
      rdata_o   <= 8'h00;
      rd_done_o <= 1'b0;
      wr_done_o <= 1'b0;
    end else begin
      rd_done_o <= 1'b0;
      wr_done_o <= 1'b0;
      unique case (st_r)
        ST_IDLE: begin
          cnt_r  <= 8'h00;
          addr_r <= addr_i;
          data_r <= wdata_i;
          if (wr_start_i) begin
            st_r <= ST_WRITE;
          end else if (rd_start_i) begin
            st_r <= ST_READ;
          end
        end
        ST_READ: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(RD_CYC - 1)) begin // R23
            rdata_o   <= mem[addr_r];
            rd_done_o <= 1'b1;
            st_r      <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (tick) begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == 8'(WR_TICKS - 1)) begin // R12
              wr_done_o <= 1'b1;
              st_r      <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (st_r == ST_WRITE && tick && cnt_r == 8'(WR_TICKS - 1)) begin
      mem[addr_r] <= data_r;
    end
  end
endmodule // nac_store

//--- rtl/nac_ctrl.sv
/*
  nonvolatile data access controller: special function registers, indirect
  control register, strobes, byte register and write-end interrupt.
  assumes a one-cycle register port from the core and a separate timer tick.
*/
`timescale 1ns/1ps
module nac_ctrl
  import nac_pkg::*;
#(
  parameter int unsigned AW       = NAC_ADDR_W,
  parameter int unsigned RD_CYC   = NAC_RD_CYCLES,
  parameter int unsigned WR_TICKS = NAC_WR_TICKS
)(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       wr_timer_i,
  input  wire logic       stack_full_i,
  input  wire logic       irq_ack_i,
  output logic            irq_req_o
);
  initial begin
    if (AW < 1 || AW > 8) begin
      $error("nac_ctrl: address width out of range");
    end
  end

  logic [7:0]    bank_select_r;
  logic [7:0]    pointer_one_r;
  logic [AW-1:0] nvm_index_r;
  logic [7:0]    nvm_byte_r;
  logic          program_permit_r;
  logic          fetch_permit_r;
  logic          wr_strobe_r;
  logic          rd_strobe_r;
  logic          global_irq_enable_r;
  logic          nvm_irq_enable_r;
  logic          mf_irq_enable_r;
  logic          nvm_irq_flag_r;
  logic          mf_irq_flag_r;
  logic [7:0]    st_rdata;
  logic          rd_done;
  logic          wr_done;
  logic          ctrl_hit;
  logic          ctrl_wr;
  logic          wr_start;
  logic          rd_start;
  logic [7:0]    ctrl_val;
  logic [7:0]    irq_val;

  function automatic logic is_wr(input logic [7:0] ofs);
    is_wr = sfr_wr_i && (sfr_addr_i == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // indirect decode and strobe start
  assign ctrl_hit = (bank_select_r == NAC_CTRL_BANK) &&
                    (pointer_one_r == NAC_CTRL_ADDR); // R21
  assign ctrl_wr  = is_wr(NAC_OFS_IND1) && ctrl_hit;
  assign wr_start = ctrl_wr && sfr_wdata_i[NAC_B_WR_STB] &&
                    program_permit_r && !wr_strobe_r &&
                    !rd_strobe_r; // R1 R3
  assign rd_start = ctrl_wr && sfr_wdata_i[NAC_B_RD_STB] &&
                    fetch_permit_r && !rd_strobe_r && !wr_strobe_r &&
                    !sfr_wdata_i[NAC_B_WR_STB]; // R4 R6
  assign ctrl_val = {4'h0, program_permit_r, wr_strobe_r,
                     fetch_permit_r, rd_strobe_r}; // R19
  assign irq_val  = {3'h0, mf_irq_flag_r, nvm_irq_flag_r, mf_irq_enable_r,
                     nvm_irq_enable_r, global_irq_enable_r};

  ////////////////////////////////////////////////////////////////////////
  // pointer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_select_r <= NAC_RST_BANK; // R14
      pointer_one_r <= 8'h00;
    end else begin
      if (is_wr(NAC_OFS_BANK)) begin
        bank_select_r <= sfr_wdata_i;
      end
      if (is_wr(NAC_OFS_PTR1)) begin
        pointer_one_r <= sfr_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // index and byte registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nvm_index_r <= '0;
      nvm_byte_r  <= 8'h00;
    end else begin
      if (is_wr(NAC_OFS_INDEX)) begin
        nvm_index_r <= sfr_wdata_i[AW-1:0]; // R22
      end
      if (rd_done) begin
        nvm_byte_r <= st_rdata; // R8
      end else if (is_wr(NAC_OFS_BYTE)) begin
        nvm_byte_r <= sfr_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register: permits by software, strobes cleared by hardware
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_permit_r <= NAC_RST_CTRL[NAC_B_WR_PERM]; // R13
      fetch_permit_r   <= NAC_RST_CTRL[NAC_B_RD_PERM];
      wr_strobe_r      <= NAC_RST_CTRL[NAC_B_WR_STB];
      rd_strobe_r      <= NAC_RST_CTRL[NAC_B_RD_STB];
    end else begin
      if (ctrl_wr) begin
        program_permit_r <= sfr_wdata_i[NAC_B_WR_PERM];
        fetch_permit_r   <= sfr_wdata_i[NAC_B_RD_PERM];
      end
      if (wr_start) begin
        wr_strobe_r <= 1'b1; // R2
      end else if (wr_done) begin
        wr_strobe_r <= 1'b0; // R2
      end
      if (rd_start) begin
        rd_strobe_r <= 1'b1; // R5
      end else if (rd_done) begin
        rd_strobe_r <= 1'b0; // R5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt enables and flags; the write-end set wins over any clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_irq_enable_r <= NAC_RST_IRQ[NAC_B_GIE];
      nvm_irq_enable_r    <= NAC_RST_IRQ[NAC_B_NIE];
      mf_irq_enable_r     <= NAC_RST_IRQ[NAC_B_MIE];
      nvm_irq_flag_r      <= NAC_RST_IRQ[NAC_B_NIF];
      mf_irq_flag_r       <= NAC_RST_IRQ[NAC_B_MIF];
    end else begin
      if (is_wr(NAC_OFS_IRQ)) begin
        global_irq_enable_r <= sfr_wdata_i[NAC_B_GIE];
        nvm_irq_enable_r    <= sfr_wdata_i[NAC_B_NIE];
        mf_irq_enable_r     <= sfr_wdata_i[NAC_B_MIE];
      end
      if (wr_done) begin
        nvm_irq_flag_r <= 1'b1; // R15
      end else if (is_wr(NAC_OFS_IRQ)) begin
        nvm_irq_flag_r <= sfr_wdata_i[NAC_B_NIF]; // R17
      end
      if (wr_done) begin
        mf_irq_flag_r <= 1'b1; // R15
      end else if (irq_ack_i) begin
        mf_irq_flag_r <= 1'b0; // R17
      end else if (is_wr(NAC_OFS_IRQ)) begin
        mf_irq_flag_r <= sfr_wdata_i[NAC_B_MIF];
      end
    end
  end

  assign irq_req_o = global_irq_enable_r && nvm_irq_enable_r &&
                     mf_irq_enable_r && mf_irq_flag_r &&
                     !stack_full_i; // R16

  ////////////////////////////////////////////////////////////////////////
  // register read port, one cycle latency, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        NAC_OFS_IND1:  sfr_rdata_o <= ctrl_hit ? ctrl_val : 8'h00;
        NAC_OFS_PTR1:  sfr_rdata_o <= pointer_one_r;
        NAC_OFS_BANK:  sfr_rdata_o <= bank_select_r;
        NAC_OFS_IRQ:   sfr_rdata_o <= irq_val;
        NAC_OFS_INDEX: sfr_rdata_o <= 8'(nvm_index_r);
        NAC_OFS_BYTE:  sfr_rdata_o <= nvm_byte_r;
        default:       sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  nac_store #(
    .AW       (AW),
    .RD_CYC   (RD_CYC),
    .WR_TICKS (WR_TICKS)
  ) u_store (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_timer_i (wr_timer_i),
    .rd_start_i (rd_start),
    .wr_start_i (wr_start),
    .addr_i     (nvm_index_r),
    .wdata_i    (nvm_byte_r),
    .rdata_o    (st_rdata),
    .rd_done_o  (rd_done),
    .wr_done_o  (wr_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic ctrl_rd_q;
  always_ff @(posedge clk_i) begin
    ctrl_rd_q <= !rst_i && sfr_rd_i && (sfr_addr_i == NAC_OFS_IND1);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_wr_gate_open: assert property ( // R1
    $rose(wr_strobe_r) |-> $past(program_permit_r))
    else $error("write started without permit");
  a_wr_strobe_hold: assert property ( // R3
    (ctrl_wr && sfr_wdata_i[NAC_B_WR_STB] && !program_permit_r
     && !wr_strobe_r) |=> !wr_strobe_r)
    else $error("write strobe set without prior permit");
  a_wr_end_clear: assert property ( // R2
    wr_done |=> !wr_strobe_r ##1 (!wr_strobe_r || $past(wr_start)))
    else $error("write strobe not cleared at end");
  a_rd_gate_open: assert property ( // R6
    $rose(rd_strobe_r) |-> $past(fetch_permit_r))
    else $error("read started without permit");
  a_rd_bounded: assert property ( // R23
    $rose(rd_strobe_r) |-> rd_strobe_r[*2] ##[0:2] !rd_strobe_r)
    else $error("read cycle length wrong");
  a_rd_byte_load: assert property ( // R8
    $fell(rd_strobe_r) |-> nvm_byte_r == $past(st_rdata))
    else $error("fetched byte not presented");
  a_irq_flags_set: assert property ( // R15
    wr_done |=> nvm_irq_flag_r && mf_irq_flag_r && irq_req_o ==
      (global_irq_enable_r && nvm_irq_enable_r && mf_irq_enable_r
       && !stack_full_i))
    else $error("write end flags not set");
  a_ack_only_mf: assert property ( // R17
    (irq_ack_i && !wr_done && !is_wr(NAC_OFS_IRQ)) |=>
      !mf_irq_flag_r && nvm_irq_flag_r == $past(nvm_irq_flag_r))
    else $error("service clear wrong");
  a_irq_stack_block: assert property ( // R16
    stack_full_i |-> !irq_req_o)
    else $error("vector with full stack");
  a_rst_protect: assert property ( // R13
    $past(rst_i) |-> !program_permit_r && bank_select_r == 8'h00)
    else $error("power-on protection missing");
  a_ctrl_hi_zero: assert property ( // R19
    ctrl_rd_q |-> sfr_rdata_o[7:4] == 4'h0)
    else $error("upper control bits not zero");

  c_read_done: cover property ($fell(rd_strobe_r));
  c_write_done: cover property ($fell(wr_strobe_r));
  c_irq_req: cover property ($rose(irq_req_o));
  c_ack_clear: cover property (irq_ack_i ##1 !mf_irq_flag_r);
endmodule // nac_ctrl

//--- verif/nac_core_model.sv
/*
  core-side model: drives the register port, stack-full and service lines.
  assumes the controller samples every request on the rising clock edge.
*/
`timescale 1ns/1ps
module nac_core_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic            ack_o,
  output logic            full_o
);
  initial begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    ack_o   = 1'b0;
    full_o  = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // one write, then address and data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    rd_o    <= 1'b0;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
    @(posedge clk_i);
  endtask

  // one read, data taken once it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_o <= a;
    rd_o   <= 1'b1;
    wr_o   <= 1'b0;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rdata_i;
  endtask

  // interrupt service pulse
  task automatic ack();
    ack_o <= 1'b1;
    @(posedge clk_i);
    ack_o <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic stack(input logic f);
    full_o <= f;
    @(posedge clk_i);
  endtask
endmodule // nac_core_model

//--- verif/test_data_eeprom_access_control.sv
/*
  self-checking bench for the nonvolatile access controller.
  assumes nac_core_model as the core and a reduced write timer count.
*/
`timescale 1ns/1ps
module test_data_eeprom_access_control;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } nac_row_t;

  logic       clk_i;
  logic       rst_i;
  logic       wr_tick;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       wr;
  logic       rd;
  logic       ack;
  logic       full;
  logic       irq;
  logic [7:0] v;
  int         error_cnt;
  int         comparisons;
  int         n;
  nac_row_t   rows [0:11] = '{
    '{8'h03, 8'h40, 8'h40}, '{8'h04, 8'h01, 8'h01},
    '{8'h1E, 8'hFF, 8'h7F}, '{8'h1F, 8'hA5, 8'hA5},
    '{8'h10, 8'h55, 8'h00}, '{8'h02, 8'hF2, 8'h02},
    '{8'h02, 8'h00, 8'h00}, '{8'h02, 8'h04, 8'h00},
    '{8'h02, 8'h01, 8'h00}, '{8'h02, 8'h0C, 8'h08},
    '{8'h02, 8'h00, 8'h00}, '{8'h02, 8'h03, 8'h02}};

  nac_ctrl #(.WR_TICKS(2)) i_nac_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .wr_timer_i(wr_tick), .stack_full_i(full), .irq_ack_i(ack),
    .irq_req_o(irq));

  nac_core_model i_nac_core_model (
    .clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .ack_o(ack), .full_o(full));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    wr_tick = 1'b0;
    #3;
    forever #73 wr_tick = ~wr_tick;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_nac_core_model.wr(a, d);
  endtask

  task automatic r(input logic [7:0] a, input logic [7:0] e);
    i_nac_core_model.rd(a, v);
    check(v, e);
  endtask

  // bounded poll of one control bit until it clears
  task automatic poll(input int b);
    n = 0;
    do begin
      i_nac_core_model.rd(8'h02, v);
      n++;
    end while (v[b] !== 1'b0 && n < 200);
    if (v[b] !== 1'b0) begin
      error_cnt++;
      $display("MISMATCH t=%0t control bit stuck", $time);
      test_done();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({7'h00, irq}, 8'h00);
    foreach (rows[i]) begin
      w(rows[i].a, rows[i].d);
      r(rows[i].a, rows[i].e);
    end
    // write cycle with interrupt
    w(8'h02, 8'h00);
    w(8'h1E, 8'h12);
    w(8'h1F, 8'h3C);
    w(8'h0E, 8'h06);
    w(8'h02, 8'h08);
    w(8'h02, 8'h0C);
    w(8'h0E, 8'h07);
    r(8'h02, 8'h0C);
    poll(2);
    r(8'h02, 8'h08);
    r(8'h0E, 8'h1F);
    check({7'h00, irq}, 8'h01);
    i_nac_core_model.stack(1'b1);
    check({7'h00, irq}, 8'h00);
    i_nac_core_model.stack(1'b0);
    i_nac_core_model.ack();
    r(8'h0E, 8'h0F);
    check({7'h00, irq}, 8'h00);
    w(8'h0E, 8'h00);
    r(8'h0E, 8'h00);
    w(8'h02, 8'h00);
    // read back of the written byte
    w(8'h1F, 8'h00);
    w(8'h02, 8'h02);
    w(8'h02, 8'h03);
    poll(0);
    check({7'h00, n <= 3}, 8'h01);
    r(8'h02, 8'h02);
    r(8'h1F, 8'h3C);
    r(8'h1F, 8'h3C);
    // reset in mid-run with write permit set
    w(8'h02, 8'h08);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    r(8'h04, 8'h00);
    w(8'h04, 8'h01);
    r(8'h02, 8'h00);
    w(8'h03, 8'h40);
    r(8'h02, 8'h00);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    test_done();
  end
endmodule // test_data_eeprom_access_control
